// *** verilog/pacr_regs.sv ***
// Alarm, identity, reset/calibrate and loss-monitor register bank
`timescale 1ns/1ps
`default_nettype none
`include "pacr_cfg.svh"
module pacr_regs #(
  parameter logic [11:0] PART_NUMBER      = 12'hA5C, // Arbitrary value
  parameter logic [3:0]  REVISION         = 4'h1,    // Arbitrary value
  parameter int          SOFT_RST_CYCLES  = `PACR_SOFT_RST_CYCLES,
  parameter int          SLOW_LOSS_CYCLES = `PACR_SLOW_LOSS_CYCLES,
  parameter logic [6:0]  DEV_ADDR         = `PACR_DEV_ADDR
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_n,
  input  wire pacr_pkg::pacr_alarm_type alarm_live_raw,
  input  wire pacr_pkg::pacr_alarm_type alarm_mask,
  input  wire logic                     irq_pin_enable,
  input  wire logic                     cal_sensitive_change,
  output logic                          irq,
  output logic                          clk_out_enable,
  output logic                          internal_reset_n,
  output logic                          self_calibrate_start,
  output logic                          recal_needed,
  output logic                          slow_detector_enable,
  output logic                          fast_detector_enable
);
  import pacr_pkg::*;

  pacr_wr_type    wr;           // Write strobe from port
  logic [7:0]     rd_addr;      // Read pointer from port
  logic [7:0]     rd_data;      // Read mux result
  pacr_alarm_type live_meta;    // First sync stage
  pacr_alarm_type live;         // Synced live alarms
  logic           lol_prev;     // Lock loss, one cycle ago
  logic [15:0]    slow_cnt;     // Slow detector persistence
  logic           in_sticky;    // input_signal_loss_sticky
  logic           ref_sticky;   // reference_signal_loss_sticky
  logic           lol_sticky;   // lock_loss_sticky
  logic           mon_hi;       // Monitor select upper bit
  logic           mon_lo;       // Monitor select lower bit
  logic           cal_pending;  // self_calibrate_trigger readback
  logic [7:0]     soft_cnt;     // Soft reset hold counter
  logic           core_rst_n;   // Pin or soft reset, low active

  // Next flag value: live sets, zero write clears
  function automatic logic sticky_next(input logic flag, input logic set, input logic clr);
    return set | (flag & ~clr);
  endfunction

  // Management port
  pacr_i2c #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .clk      (clk),
    .rst_n    (core_rst_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe_n (sda_oe_n),
    .wr       (wr),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  // Open-drain data pin only ever pulls low
  assign sda_out = 1'b0;

  // Write decoding
  wire wr_los  = wr.valid && (wr.addr == `PACR_ADDR_LOS_FLAGS);
  wire wr_lol  = wr.valid && (wr.addr == `PACR_ADDR_LOL_FLAG);
  wire wr_rc   = wr.valid && (wr.addr == `PACR_ADDR_RST_CAL);
  wire wr_mhi  = wr.valid && (wr.addr == `PACR_ADDR_MON_HI);
  wire wr_mlo  = wr.valid && (wr.addr == `PACR_ADDR_MON_LO);
  wire soft_wr = wr_rc && wr.data[`PACR_BIT_SOFT_RST];
  wire cal_wr  = wr_rc && wr.data[`PACR_BIT_CAL] && !soft_wr;

  // Zero writes clear flags
  wire clr_in  = wr_los && !wr.data[`PACR_BIT_IN_LOSS];
  wire clr_ref = wr_los && !wr.data[`PACR_BIT_REF_LOSS];
  wire clr_lol = wr_lol && !wr.data[`PACR_BIT_LOCK_LOSS];

  // Monitor mode decode
  wire [1:0] mon_sel = {mon_hi, mon_lo};
  wire mode_slow = (mon_sel == `PACR_MON_SLOW);
  wire mode_fast = (mon_sel == `PACR_MON_FAST);
  wire slow_hit  = (slow_cnt == 16'(SLOW_LOSS_CYCLES));
  // Slow path waits for persistence; off masks it
  wire in_loss_eff = (mode_fast && live.input_loss) ||
                     (mode_slow && live.input_loss && slow_hit);
  wire lol_fall  = lol_prev && !live.lock_loss;
  wire irq_cause = irq_pin_enable &&
                   ((in_sticky && !alarm_mask.input_loss) ||
                    (ref_sticky && !alarm_mask.reference_loss) ||
                    (lol_sticky && !alarm_mask.lock_loss));

  assign slow_detector_enable = mode_slow;
  assign fast_detector_enable = mode_fast;
  assign internal_reset_n     = core_rst_n;
  assign core_rst_n           = resetn && (soft_cnt == 8'h00);

  // Read mux; reserved bits read zero or fixed pattern
  assign rd_data =
    (rd_addr == `PACR_ADDR_IN_LIVE)   ? {6'h00, live.input_loss, live.reference_loss} :
    (rd_addr == `PACR_ADDR_LOL_LIVE)  ? {7'h00, live.lock_loss} :
    (rd_addr == `PACR_ADDR_LOS_FLAGS) ? {6'h00, in_sticky, ref_sticky} :
    (rd_addr == `PACR_ADDR_LOL_FLAG)  ? {6'h00, lol_sticky, 1'b0} :
    (rd_addr == `PACR_ADDR_PART_HI)   ? PART_NUMBER[11:4] :
    (rd_addr == `PACR_ADDR_PART_LO)   ? {PART_NUMBER[3:0], REVISION} :
    (rd_addr == `PACR_ADDR_RST_CAL)   ? {1'b0, cal_pending, 6'h00} :
    (rd_addr == `PACR_ADDR_MON_HI)    ? ((`PACR_RST_MON_HI & 8'hFE) | {7'h00, mon_hi}) :
    (rd_addr == `PACR_ADDR_MON_LO)    ? ((`PACR_RST_MON_LO & 8'hEF) | {3'h0, mon_lo, 4'h0}) :
    8'h00;

  // Soft reset hold counter, pin reset only
  always_ff @(posedge clk) begin
    if (!resetn) soft_cnt <= 8'h00;
    else if (soft_wr) soft_cnt <= 8'(SOFT_RST_CYCLES);
    else if (soft_cnt != 8'h00) soft_cnt <= soft_cnt - 8'h01;
  end

  // Clock outputs stopped during any reset
  always_ff @(posedge clk) begin
    if (!core_rst_n) clk_out_enable <= 1'b0;
    else clk_out_enable <= 1'b1;
  end

  // Live alarm synchronisers
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin
      live_meta <= '0;
      live      <= '0;
      lol_prev  <= 1'b0;
    end else begin
      live_meta <= alarm_live_raw;
      live      <= live_meta;
      lol_prev  <= live.lock_loss;
    end
  end

  // Slow detector persistence counter
  always_ff @(posedge clk) begin
    if (!core_rst_n || !live.input_loss) slow_cnt <= 16'h0000;
    else if (!slow_hit) slow_cnt <= slow_cnt + 16'h0001;
  end

  // Sticky alarm flags, set wins over clear
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin
      in_sticky  <= 1'b0;
      ref_sticky <= 1'b0;
      lol_sticky <= 1'(`PACR_RST_LOL_FLAG >> `PACR_BIT_LOCK_LOSS);
    end else begin
      in_sticky  <= sticky_next(in_sticky, in_loss_eff, clr_in);
      ref_sticky <= sticky_next(ref_sticky, live.reference_loss, clr_ref);
      lol_sticky <= sticky_next(lol_sticky, live.lock_loss, clr_lol);
    end
  end

  // Interrupt output
  always_ff @(posedge clk) begin
    if (!core_rst_n) irq <= 1'b0;
    else irq <= irq_cause;
  end

  // Loss-monitor select bits
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin
      mon_hi <= 1'(`PACR_RST_MON_HI >> `PACR_BIT_MON_HI);
      mon_lo <= 1'(`PACR_RST_MON_LO >> `PACR_BIT_MON_LO);
    end else begin
      if (wr_mhi) mon_hi <= wr.data[`PACR_BIT_MON_HI];
      if (wr_mlo) mon_lo <= wr.data[`PACR_BIT_MON_LO];
    end
  end

  // Calibration trigger and completion
  always_ff @(posedge clk) begin
    if (!core_rst_n) begin
      self_calibrate_start <= 1'b0;
      cal_pending          <= 1'b0;
    end else begin
      self_calibrate_start <= cal_wr;
      if (cal_wr) cal_pending <= 1'b1;
      else if (lol_fall) cal_pending <= 1'b0;
    end
  end

  // Recalibration reminder, change wins over trigger
  always_ff @(posedge clk) begin
    if (!core_rst_n) recal_needed <= 1'b0;
    else if (cal_sensitive_change) recal_needed <= 1'b1;
    else if (cal_wr) recal_needed <= 1'b0;
  end

  // Checks

  // Outputs held off after soft reset write
  sequence s_clocks_off;
    ##1 !clk_out_enable [*8];
  endsequence
  // Calibration pulse lasts one cycle
  sequence s_cal_pulse;
    self_calibrate_start ##1 !self_calibrate_start;
  endsequence

  property p_in_set;
    @(posedge clk) disable iff (!core_rst_n) in_loss_eff |=> in_sticky;
  endproperty
  a_in_set: assert property (p_in_set) else $error("input loss flag not set");

  property p_ref_hold;
    @(posedge clk) disable iff (!core_rst_n) (live.reference_loss && !clr_ref) ##1 1'b1 |-> ref_sticky [*2];
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference flag lost");

  property p_lol_set;
    @(posedge clk) disable iff (!core_rst_n) live.lock_loss |=> lol_sticky;
  endproperty
  a_lol_set: assert property (p_lol_set) else $error("lock loss flag not set");

  property p_irq_on;
    @(posedge clk) disable iff (!core_rst_n)
      (irq_pin_enable && lol_sticky && !alarm_mask.lock_loss) |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

  property p_irq_off;
    @(posedge clk) disable iff (!core_rst_n) !irq_pin_enable |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

  property p_clear;
    @(posedge clk) disable iff (!core_rst_n) (clr_in && !in_loss_eff) |=> !in_sticky;
  endproperty
  a_clear: assert property (p_clear) else $error("zero write did not clear");

  property p_set_wins;
    @(posedge clk) disable iff (!core_rst_n) (clr_lol && live.lock_loss) |=> lol_sticky;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat live alarm");

  property p_lol_reset;
    @(posedge clk) disable iff (!resetn) $rose(core_rst_n) |-> lol_sticky && !in_sticky;
  endproperty
  a_lol_reset: assert property (p_lol_reset) else $error("lock flag reset value wrong");

  property p_soft_reset;
    @(posedge clk) disable iff (!resetn) soft_wr |=> s_clocks_off;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("clocks ran in soft reset");

  property p_cal_start;
    @(posedge clk) disable iff (!core_rst_n) cal_wr |=> s_cal_pulse and cal_pending;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration start wrong");

  property p_cal_done;
    @(posedge clk) disable iff (!core_rst_n) (cal_pending && lol_fall && !cal_wr) |=> !cal_pending;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("calibration never completed");

  property p_mon_reset;
    @(posedge clk) disable iff (!resetn) $rose(core_rst_n) |-> fast_detector_enable && !slow_detector_enable;
  endproperty
  a_mon_reset: assert property (p_mon_reset) else $error("monitor not fast after reset");

  property p_slow_lag;
    @(posedge clk) disable iff (!core_rst_n) (mode_slow && $rose(live.input_loss)) |-> !in_loss_eff [*4];
  endproperty
  a_slow_lag: assert property (p_slow_lag) else $error("slow detector too fast");
endmodule
`default_nettype wire

// *** verilog/pacr_cfg.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef PACR_CFG_SVH
`define PACR_CFG_SVH
// Register offsets
`define PACR_ADDR_IN_LIVE   8'h81
`define PACR_ADDR_LOL_LIVE  8'h82
`define PACR_ADDR_LOS_FLAGS 8'h83
`define PACR_ADDR_LOL_FLAG  8'h84
`define PACR_ADDR_PART_HI   8'h86
`define PACR_ADDR_PART_LO   8'h87
`define PACR_ADDR_RST_CAL   8'h88
`define PACR_ADDR_MON_HI    8'h8A
`define PACR_ADDR_MON_LO    8'h8B
// Field positions
`define PACR_BIT_IN_LOSS    1
`define PACR_BIT_REF_LOSS   0
`define PACR_BIT_LOCK_LOSS  1
`define PACR_BIT_LOL_LIVE   0
`define PACR_BIT_SOFT_RST   7
`define PACR_BIT_CAL        6
`define PACR_BIT_MON_HI     0
`define PACR_BIT_MON_LO     4
// Reset values
`define PACR_RST_LOL_FLAG   8'h02
`define PACR_RST_MON_HI     8'h0F
`define PACR_RST_MON_LO     8'hFF
// Loss-monitor select encodings
`define PACR_MON_OFF        2'h0
`define PACR_MON_SLOW       2'h2
`define PACR_MON_FAST       2'h3
// Timing counts, in clk cycles
`define PACR_SOFT_RST_CYCLES  16
`define PACR_SLOW_LOSS_CYCLES 64
// Management port device address
`define PACR_DEV_ADDR       7'h68
`endif

// *** verilog/pacr_pkg.sv ***
// Types shared by the register bank and its serial port
package pacr_pkg;
  // One register write from the serial port
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } pacr_wr_type;
  // Three alarm sources, also used for masks
  typedef struct packed {
    logic input_loss;
    logic reference_loss;
    logic lock_loss;
  } pacr_alarm_type;
  // Serial port states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } pacr_i2c_state_type;
endpackage

// *** verilog/pacr_i2c.sv ***
// Two-wire management port slave with auto-incrementing register pointer
`timescale 1ns/1ps
`default_nettype none
`include "pacr_cfg.svh"
module pacr_i2c #(
  parameter logic [6:0] DEV_ADDR = `PACR_DEV_ADDR
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_oe_n,
  output pacr_pkg::pacr_wr_type     wr,
  output logic [7:0]                rd_addr,
  input  wire logic [7:0]           rd_data
);
  import pacr_pkg::*;

  logic [1:0]         scl_sy;   // Pin synchronisers
  logic [1:0]         sda_sy;
  logic               scl_d;    // Previous synced levels
  logic               sda_d;
  pacr_i2c_state_type state;
  logic [3:0]         cnt;      // Bit counter
  logic [7:0]         shift;    // Receive shifter
  logic [7:0]         tx;       // Transmit byte
  logic               rw;       // Read direction
  logic               mack;     // Master acked last byte
  logic               drive_low;

  wire scl   = scl_sy[1];
  wire sda   = sda_sy[1];
  wire start = scl & scl_d & sda_d & ~sda;
  wire stop  = scl & scl_d & ~sda_d & sda;
  wire rise  = scl & ~scl_d;
  wire fall  = ~scl & scl_d;
  wire full  = (cnt == 4'h8);

  assign sda_oe_n = ~drive_low;
  assign rd_addr  = wr.addr;

  // Two-stage synchronisers and edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_sy <= 2'h3;
      sda_sy <= 2'h3;
      scl_d  <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_sy <= {scl_sy[0], scl_in};
      sda_sy <= {sda_sy[0], sda_in};
      scl_d  <= scl;
      sda_d  <= sda;
    end
  end

  // Byte protocol; pointer held in wr.addr
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      drive_low <= 1'b0;
      wr <= '0;
    end else begin
      wr.valid <= 1'b0;
      if (start) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
      end else if (rise) begin
        // Sample on rising clock
        if (state == ST_RDATA_ACK) mack <= ~sda;
        shift <= {shift[6:0], sda};
        cnt <= cnt + 4'h1;
      end else if (fall) begin
        case (state)
          ST_ADDR: if (full) begin
            // Answer only our own address
            if (shift[7:1] == DEV_ADDR) begin
              drive_low <= 1'b1;
              rw <= shift[0];
              state <= ST_ADDR_ACK;
            end else state <= ST_IDLE;
          end
          ST_ADDR_ACK: begin
            cnt <= 4'h0;
            if (rw) begin
              tx <= rd_data;
              drive_low <= ~rd_data[7];
              wr.addr <= wr.addr + 8'h01;
              state <= ST_RDATA;
            end else begin
              drive_low <= 1'b0;
              state <= ST_REG;
            end
          end
          ST_REG: if (full) begin
            drive_low <= 1'b1;
            wr.addr <= shift;
            state <= ST_REG_ACK;
          end
          ST_WDATA: if (full) begin
            drive_low <= 1'b1;
            wr.valid <= 1'b1;
            wr.data <= shift;
            state <= ST_WDATA_ACK;
          end
          ST_REG_ACK, ST_WDATA_ACK: begin
            drive_low <= 1'b0;
            cnt <= 4'h0;
            if (state == ST_WDATA_ACK) wr.addr <= wr.addr + 8'h01;
            state <= ST_WDATA;
          end
          ST_RDATA: begin
            if (full) begin
              drive_low <= 1'b0;
              state <= ST_RDATA_ACK;
            end else drive_low <= ~tx[3'(4'h7 - cnt)];
          end
          ST_RDATA_ACK: begin
            cnt <= 4'h0;
            if (mack) begin
              tx <= rd_data;
              drive_low <= ~rd_data[7];
              wr.addr <= wr.addr + 8'h01;
              state <= ST_RDATA;
            end else state <= ST_IDLE;
          end
          default: drive_low <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/pacr_i2c_host.sv ***
// Two-wire host model that writes and reads the register bank
`timescale 1ns/1ps
`default_nettype none
module pacr_i2c_host (
  input  wire logic       clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_low,
  output logic            res_valid,
  output logic [7:0]      res_data
);
  // Idle: clock line high and still, data released
  initial begin
    scl       = 1'b1;
    sda_low   = 1'b0;
    res_valid = 1'b0;
    res_data  = 8'h00;
  end
  // Wait whole clock cycles
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: data set while clock low, sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    sda_low <= ~b;
    wt(3);
    scl <= 1'b1;
    wt(2);
    @(negedge clk);
    r = sda;
    wt(2);
    scl <= 1'b0;
    wt(3);
  endtask
  // Frame start: data falls while clock high
  task automatic start();
    sda_low <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(3);
  endtask
  // Frame end: data rises while clock high
  task automatic stop();
    sda_low <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sda_low <= 1'b0;
    wt(8);
  endtask
  // Byte out, first bit most significant; returns acknowledge level
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask
  // Register write: device address, pointer, data
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, d, output logic ok);
    logic k0, k1, k2;
    start();
    send({dev, 1'b0}, k0);
    send(a, k1);
    send(d, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
  // Register read: set pointer, then one byte closed by no-acknowledge
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a);
    logic       k, r;
    logic [7:0] v;
    start();
    send({dev, 1'b0}, k);
    send(a, k);
    stop();
    start();
    send({dev, 1'b1}, k);
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      v[i] = r;
    end
    bitx(1'b1, r);
    stop();
    res_data  <= v;
    res_valid <= 1'b1;
    wt(1);
    res_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_pacr_regs.sv ***
// Self-checking bench for the alarm and calibration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_pacr_regs;
  import pacr_pkg::*;
  localparam logic [11:0] PART = 12'h3C7;  // Arbitrary value
  localparam logic [3:0]  REV  = 4'h9;     // Arbitrary value
  localparam logic [6:0]  DEV  = 7'h68;    // Port address
  localparam int          SRC  = 16;       // Soft reset length
  localparam int          SLOW = 8;        // Shortened slow filter
  // Address and value after reset
  localparam logic [15:0] RTAB [8] = '{16'h8402, {8'h86, PART[11:4]}, {8'h87, PART[3:0], REV},
    16'h8A0F, 16'h8BFF, 16'h8300, 16'h8800, 16'h9000};
  logic           clk, resetn, scl, host_low, sda_oe_n, sda_out, res_valid;
  logic           irq, irq_pin_enable, cal_sensitive_change, recal_needed, self_calibrate_start;
  logic           clk_out_enable, internal_reset_n, slow_detector_enable, fast_detector_enable;
  logic [7:0]     res_data;
  logic [7:0]     exp_q[$];           // Expected read bytes
  pacr_alarm_type alarm_live_raw, alarm_mask;
  wire logic      sda;
  int             mismatches, checks_done, cal_pulses, rst_low, oe_low, n, k;
  logic           ok;
  // Open-drain data line with pull-up
  assign sda = !(host_low || (!sda_oe_n && !sda_out));
  // Clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  pacr_regs #(.PART_NUMBER(PART), .REVISION(REV), .SOFT_RST_CYCLES(SRC),
    .SLOW_LOSS_CYCLES(SLOW), .DEV_ADDR(DEV)) u_dut (.clk, .resetn, .scl_in(scl), .sda_in(sda),
    .sda_out, .sda_oe_n, .alarm_live_raw, .alarm_mask, .irq_pin_enable, .cal_sensitive_change,
    .irq, .clk_out_enable, .internal_reset_n, .self_calibrate_start, .recal_needed,
    .slow_detector_enable, .fast_detector_enable);
  pacr_i2c_host u_host (.clk, .sda, .scl, .sda_low(host_low), .res_valid, .res_data);
  // Compare and count
  task automatic chk(input logic [7:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Each byte read is matched against the oldest expectation
  always @(posedge clk) begin
    if (res_valid === 1'b1) chk(res_data, exp_q.size() ? exp_q.pop_front() : 8'hxx, "read");
  end
  // Calibration pulses and reset cycles seen at the outputs
  always @(posedge clk) begin
    cal_pulses <= cal_pulses + (self_calibrate_start === 1'b1);
    rst_low    <= rst_low + (resetn && internal_reset_n === 1'b0);
    oe_low     <= oe_low + (resetn && clk_out_enable === 1'b0);
  end
  // Register write with acknowledge check
  task automatic wr(input logic [7:0] a, d);
    u_host.write_reg(DEV, a, d, ok);
    chk({7'h0, ok}, 8'h01, "ack");
  endtask
  // Register read, expectation noted first
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    u_host.read_reg(DEV, a);
  endtask
  // Live alarm held for n cycles, then let it settle
  task automatic pulse(input pacr_alarm_type a, input int n);
    alarm_live_raw <= a;
    repeat (n) @(posedge clk);
    alarm_live_raw <= 3'b000;
    repeat (6) @(posedge clk);
  endtask
  // Hang guard
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h312d0fab));
    {resetn, irq_pin_enable, cal_sensitive_change} = 3'b000;
    alarm_live_raw = 3'b000;
    alarm_mask = 3'b000;
    {cal_pulses, rst_low, oe_low, mismatches, checks_done} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, identity, unmapped place
    chk({6'h0, slow_detector_enable, fast_detector_enable}, 8'h01, "mode");
    foreach (RTAB[i]) rd(RTAB[i][15:8], RTAB[i][7:0]);
    wr(8'h86, 8'($urandom));
    wr(8'h87, 8'($urandom));
    rd(8'h86, PART[11:4]);
    rd(8'h87, {PART[3:0], REV});
    // Wrong device address is refused
    u_host.write_reg(DEV ^ 7'h01, 8'h8A, 8'h00, ok);
    chk({7'h0, ok}, 8'h00, "nack");
    rd(8'h8A, 8'h0F);
    // Every monitor mode, random reserved bits, fast and slow detection
    for (int m = 0; m < 4; m++) begin
      wr(8'h8A, (8'($urandom) & 8'hFE) | 8'(m >> 1));
      wr(8'h8B, (8'($urandom) & 8'hEF) | 8'((m & 1) << 4));
      rd(8'h8A, 8'h0E | 8'(m >> 1));
      rd(8'h8B, 8'hEF | 8'((m & 1) << 4));
      chk({6'h0, slow_detector_enable, fast_detector_enable}, {6'h0, m == 2, m == 3}, "mode");
      pulse(3'b100, 3);
      rd(8'h83, {6'h0, m == 3, 1'b0});
      pulse(3'b100, SLOW + 6);
      rd(8'h83, {6'h0, m >= 2, 1'b0});
      wr(8'h83, 8'h00);
    end
    // Each flag: masked, kept through a zero write while live, raised, kept by ones, cleared
    irq_pin_enable <= 1'b1;
    wr(8'h84, 8'h00);
    for (int i = 0; i < 3; i++) begin
      alarm_live_raw <= 3'(1 << i);
      alarm_mask     <= 3'(1 << i);
      repeat (6) @(posedge clk);
      chk({7'h0, irq}, 8'h00, "masked irq");
      rd(i == 0 ? 8'h82 : 8'h81, i == 0 ? 8'h01 : 8'(i));
      wr(i == 0 ? 8'h84 : 8'h83, 8'h00);
      rd(i == 0 ? 8'h84 : 8'h83, i == 0 ? 8'h02 : 8'(i));
      alarm_live_raw <= 3'b000;
      alarm_mask     <= 3'b000;
      repeat (6) @(posedge clk);
      chk({7'h0, irq}, 8'h01, "irq");
      irq_pin_enable <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h00, "disabled irq");
      irq_pin_enable <= 1'b1;
      wr(i == 0 ? 8'h84 : 8'h83, 8'hFF);
      rd(i == 0 ? 8'h84 : 8'h83, i == 0 ? 8'h02 : 8'(i));
      wr(i == 0 ? 8'h84 : 8'h83, 8'h00);
      rd(i == 0 ? 8'h84 : 8'h83, 8'h00);
      chk({7'h0, irq}, 8'h00, "cleared irq");
    end
    // Calibration after a sensitive change, done when lock returns
    cal_sensitive_change <= 1'b1;
    @(posedge clk);
    cal_sensitive_change <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h0, recal_needed}, 8'h01, "recal");
    alarm_live_raw <= 3'b001;
    n = cal_pulses;
    wr(8'h88, 8'h40);
    chk(8'(cal_pulses - n), 8'h01, "cal pulse");
    chk({7'h0, recal_needed}, 8'h00, "recal");
    rd(8'h88, 8'h40);
    alarm_live_raw <= 3'b000;
    repeat (6) @(posedge clk);
    rd(8'h88, 8'h00);
    // Soft reset restores every register and stops the clocks
    wr(8'h84, 8'h00);
    wr(8'h8A, 8'h00);
    n = rst_low;
    k = oe_low;
    u_host.write_reg(DEV, 8'h88, 8'h80, ok);
    repeat (40) @(posedge clk);
    chk(8'(rst_low - n), 8'(SRC), "soft reset");
    chk(8'(oe_low - k), 8'(SRC), "clock stop");
    repeat (200) @(posedge clk);
    foreach (RTAB[i]) rd(RTAB[i][15:8], RTAB[i][7:0]);
    repeat (4) @(posedge clk);
    chk(8'(exp_q.size()), 8'h00, "missing reads");
    give_verdict();
  end
endmodule
`default_nettype wire
